// >>> smbus_flags_and_controller_modes.sv
/*
  Serial bus flag logic, byte shift register and controller transfer
  sequencing (start, byte frames, acknowledge, repeated start, stop).
  Assumes open-drain sda/scl resolved outside, pins asynchronous to
  i_clock, and a cpu port that accesses the byte register only while
  the byte event flag is set.
*/
`include "smbus_flags_cfg.svh"
module smbus_flags_and_controller_modes #(
  parameter int HALF_CYC = `SB_HALF_CYC
) (
  input logic i_clock,
  input logic i_rst_b,
  input logic i_enable,
  input logic i_reg_wr,
  input logic i_reg_sel,
  input logic [7:0] i_reg_wdata,
  output smbus_flags_pkg::ctrl_t o_ctrl,
  output logic [7:0] o_data,
  input logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input logic i_scl,
  output logic o_scl,
  output logic o_scl_oe
);
  localparam int TW = $clog2(HALF_CYC + 1);
  localparam logic [TW-1:0] T_LAST = TW'(HALF_CYC - 1);

  logic sda_s1, sda_s2, sda_s3, scl_s1, scl_s2, scl_s3;
  logic start_det, stop_det, scl_rise, scl_fall;

  smbus_flags_pkg::state_t state_reg, state_next;
  smbus_flags_pkg::ctrl_t ctrl_reg, ctrl_next;
  logic [7:0] data_reg, data_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [1:0] step_reg, step_next;
  logic [TW-1:0] timer_reg, timer_next;
  logic hi_reg, hi_next;
  logic ack_pend_reg, ack_pend_next;
  logic addr_ph_reg, addr_ph_next;
  logic written_reg, written_next;
  logic busy_reg, busy_next;
  logic is_stop_reg, is_stop_next;
  logic sda_oe_reg, sda_oe_next;
  logic scl_oe_reg, scl_oe_next;
  logic go_next, lose, tdone, drive, fall;

  // pins pass two flops; the third stage only feeds edge detection
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
    end else begin
      sda_s1 <= i_sda;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      scl_s1 <= i_scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
    end
  end

  // bus conditions (sda moving while scl stays high), then scl edges
  assign start_det = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_det = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
  assign scl_rise = scl_s2 && !scl_s3;
  assign scl_fall = !scl_s2 && scl_s3;

  // next-state logic for the whole engine
  always_comb begin
    state_next = state_reg;
    ctrl_next = ctrl_reg;
    data_next = data_reg;
    cnt_next = cnt_reg;
    step_next = step_reg;
    timer_next = timer_reg;
    hi_next = hi_reg;
    ack_pend_next = ack_pend_reg;
    addr_ph_next = addr_ph_reg;
    written_next = written_reg;
    busy_next = busy_reg;
    is_stop_next = is_stop_reg;
    sda_oe_next = sda_oe_reg;
    scl_oe_next = scl_oe_reg;
    go_next = 1'b0;
    lose = 1'b0;
    fall = 1'b0;
    tdone = (timer_reg == T_LAST);
    // ack bit drives the chosen reply; data bits drive only zeros
    drive = (cnt_reg == 4'h8) ? (!ctrl_reg.sending && ctrl_reg.reply_pol)
                              : (ctrl_reg.sending && !data_reg[7]);

    if (start_det) busy_next = 1'b1;
    if (stop_det) busy_next = 1'b0;

    // cpu writes; hardware sets further down win over these clears
    if (i_reg_wr && i_reg_sel == `SB_DATA_SEL) begin
      data_next = i_reg_wdata;
      written_next = 1'b1;
    end
    if (i_reg_wr && i_reg_sel == `SB_CTRL_SEL) begin
      ctrl_next.begin_req = i_reg_wdata[`SB_BIT_BEGIN];
      ctrl_next.end_req = i_reg_wdata[`SB_BIT_END];
      ctrl_next.reply_pol = i_reg_wdata[`SB_BIT_REPLY_POL];
      if (!i_reg_wdata[`SB_BIT_BYTE_EVENT] && ctrl_reg.byte_event) begin
        ctrl_next.byte_event = 1'b0;
        ctrl_next.contention = 1'b0;
      end
    end

    case (state_reg)
      smbus_flags_pkg::ST_IDLE: begin
        sda_oe_next = 1'b0;
        scl_oe_next = 1'b0;
        // a start waits for a free bus and a cleared event
        if (i_enable && ctrl_reg.begin_req && !busy_reg && !ctrl_reg.byte_event) begin
          state_next = smbus_flags_pkg::ST_COND;
          is_stop_next = 1'b0;
          step_next = 2'd2;
          sda_oe_next = 1'b1;
          timer_next = '0;
        end
      end
      smbus_flags_pkg::ST_COND: begin
        timer_next = tdone ? '0 : timer_reg + 1'b1;
        if (tdone) begin
          case (step_reg)
            2'd0: begin
              scl_oe_next = 1'b0;
              step_next = 2'd1;
            end
            2'd1: begin
              if (!scl_s2) begin
                lose = 1'b1;
              end else begin
                sda_oe_next = !is_stop_reg;
                step_next = 2'd2;
              end
            end
            default: begin
              if (is_stop_reg) begin
                ctrl_next.role = 1'b0;
                ctrl_next.end_req = 1'b0;
                state_next = smbus_flags_pkg::ST_IDLE;
              end else begin
                scl_oe_next = 1'b1;
                ctrl_next.role = 1'b1;
                ctrl_next.sending = 1'b1;
                ctrl_next.byte_event = 1'b1;
                written_next = 1'b0;
                addr_ph_next = 1'b1;
                ack_pend_next = 1'b0;
                state_next = smbus_flags_pkg::ST_HOLD;
              end
            end
          endcase
        end
      end
      smbus_flags_pkg::ST_HOLD: begin
        scl_oe_next = 1'b1;
        if (!ctrl_reg.byte_event) begin
          if (ack_pend_reg) begin
            state_next = smbus_flags_pkg::ST_BITS;
            cnt_next = 4'h8;
            hi_next = 1'b0;
            timer_next = '0;
            ack_pend_next = 1'b0;
          end else begin
            go_next = 1'b1;
          end
        end
      end
      smbus_flags_pkg::ST_BITS: begin
        if (!hi_reg) begin
          sda_oe_next = drive;
          // controller lets scl rise after a half period; target waits
          if (ctrl_reg.role) begin
            if (!tdone) timer_next = timer_reg + 1'b1;
            else scl_oe_next = 1'b0;
          end
          if (scl_rise) begin
            hi_next = 1'b1;
            timer_next = '0;
            if (cnt_reg != 4'h8) begin
              data_next = {data_reg[6:0], sda_s2};
              if (ctrl_reg.role && ctrl_reg.sending && !sda_oe_reg && !sda_s2) begin
                lose = 1'b1;
              end
            end else if (ctrl_reg.sending) begin
              ctrl_next.reply_pol = !sda_s2;
            end
          end
        end else if (ctrl_reg.role) begin
          timer_next = timer_reg + 1'b1;
          if (tdone) begin
            scl_oe_next = 1'b1;
            fall = 1'b1;
          end
        end else begin
          fall = scl_fall;
        end
        if (fall) begin
          hi_next = 1'b0;
          timer_next = '0;
          if (cnt_reg == 4'h8) begin
            ctrl_next.reply_needed = 1'b0;
            sda_oe_next = 1'b0;
            addr_ph_next = 1'b0;
            if (ctrl_reg.sending) begin
              ctrl_next.byte_event = 1'b1;
              state_next = smbus_flags_pkg::ST_HOLD;
              scl_oe_next = 1'b1;
            end else begin
              go_next = 1'b1;
            end
          end else if (cnt_reg == 4'h7 && !ctrl_reg.sending) begin
            // receive: the event comes before the ack bit
            ctrl_next.byte_event = 1'b1;
            ctrl_next.reply_needed = 1'b1;
            if (addr_ph_reg && !ctrl_reg.role) ctrl_next.begin_req = 1'b1;
            addr_ph_next = 1'b0;
            ack_pend_next = 1'b1;
            sda_oe_next = 1'b0;
            scl_oe_next = 1'b1;
            state_next = smbus_flags_pkg::ST_HOLD;
          end else begin
            cnt_next = cnt_reg + 4'h1;
          end
        end
      end
      default: begin
        state_next = smbus_flags_pkg::ST_IDLE;
      end
    endcase

    // after an event or ack: stop, restart, or next frame
    if (go_next) begin
      timer_next = '0;
      if (ctrl_reg.role && ctrl_reg.end_req) begin
        state_next = smbus_flags_pkg::ST_COND;
        is_stop_next = 1'b1;
        step_next = 2'd0;
        sda_oe_next = 1'b1;
      end else if (ctrl_reg.role && ctrl_reg.begin_req) begin
        state_next = smbus_flags_pkg::ST_COND;
        is_stop_next = 1'b0;
        step_next = 2'd0;
        sda_oe_next = 1'b0;
      end else begin
        // direction follows whether the byte register was loaded
        state_next = smbus_flags_pkg::ST_BITS;
        ctrl_next.sending = written_reg;
        written_next = 1'b0;
        cnt_next = 4'h0;
        hi_next = 1'b0;
        scl_oe_next = ctrl_reg.role;
      end
    end

    // conditions made by others; our own are ignored while generating
    if (state_reg != smbus_flags_pkg::ST_COND) begin
      if (start_det) begin
        ctrl_next.sending = 1'b0;
        if (ctrl_reg.role) begin
          if (!ctrl_reg.begin_req) lose = 1'b1;
        end else begin
          state_next = smbus_flags_pkg::ST_BITS;
          cnt_next = 4'h0;
          hi_next = 1'b0;
          addr_ph_next = 1'b1;
          scl_oe_next = 1'b0;
          sda_oe_next = 1'b0;
        end
      end
      if (stop_det) begin
        if (ctrl_reg.role || state_reg != smbus_flags_pkg::ST_IDLE) begin
          ctrl_next.end_req = 1'b1;
          ctrl_next.byte_event = 1'b1;
        end
        if (ctrl_reg.role) lose = 1'b1;
        state_next = smbus_flags_pkg::ST_IDLE;
        sda_oe_next = 1'b0;
        scl_oe_next = 1'b0;
      end
    end

    // lost arbitration: drop to target receiver; a frame in ST_BITS keeps shifting, otherwise go idle
    if (lose) begin
      ctrl_next.role = 1'b0;
      ctrl_next.sending = 1'b0;
      ctrl_next.contention = 1'b1;
      ctrl_next.byte_event = 1'b1;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
      if (state_next != smbus_flags_pkg::ST_BITS) state_next = smbus_flags_pkg::ST_IDLE;
    end

    // disabled: let go of both lines at once
    if (!i_enable) begin
      state_next = smbus_flags_pkg::ST_IDLE;
      sda_oe_next = 1'b0;
      scl_oe_next = 1'b0;
    end
  end

  // registers of the engine
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= smbus_flags_pkg::ST_IDLE;
      ctrl_reg <= smbus_flags_pkg::ctrl_t'(`SB_CTRL_RST);
      data_reg <= `SB_DATA_RST;
      cnt_reg <= 4'h0;
      step_reg <= 2'd0;
      timer_reg <= '0;
      hi_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
      addr_ph_reg <= 1'b0;
      written_reg <= 1'b0;
      busy_reg <= 1'b0;
      is_stop_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      o_sda <= 1'b0;
      o_scl <= 1'b0;
    end else begin
      state_reg <= state_next;
      ctrl_reg <= ctrl_next;
      data_reg <= data_next;
      cnt_reg <= cnt_next;
      step_reg <= step_next;
      timer_reg <= timer_next;
      hi_reg <= hi_next;
      ack_pend_reg <= ack_pend_next;
      addr_ph_reg <= addr_ph_next;
      written_reg <= written_next;
      busy_reg <= busy_next;
      is_stop_reg <= is_stop_next;
      sda_oe_reg <= sda_oe_next;
      scl_oe_reg <= scl_oe_next;
      o_sda <= 1'b0; // open drain: only the enable ever changes
      o_scl <= 1'b0;
    end
  end

  // outputs come straight from the registers
  assign o_ctrl = ctrl_reg;
  assign o_data = data_reg;
  assign o_sda_oe = sda_oe_reg;
  assign o_scl_oe = scl_oe_reg;
endmodule

// >>> smbus_flags_and_controller_modes_tb.sv
/*
  Self-checking bench: controller write and read transfers against a
  target model. Assumes pulled-up lines and a short half period.
*/
module smbus_flags_and_controller_modes_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 4; // 220 ns scl period keeps the run short
  localparam logic [7:0] RD = 8'h96;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_enable = 1'b1;
  logic i_reg_wr = 1'b0;
  logic i_reg_sel = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  smbus_flags_pkg::ctrl_t o_ctrl;
  logic [7:0] o_data;
  logic dut_sda_oe;
  logic dut_scl_oe;
  logic mdl_sda_oe;
  logic [7:0] mdl_got;
  logic tb_sda_oe = 1'b0; // a rival controller holding sda low
  int miscompares = 0;
  int checks = 0;
  // wired AND with pull-ups
  wire sda_line = ~(dut_sda_oe | mdl_sda_oe | tb_sda_oe);
  wire scl_line = ~dut_scl_oe;
  smbus_flags_and_controller_modes #(.HALF_CYC(HALF)) smbus_flags_and_controller_modes_i (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_enable(i_enable), .i_reg_wr(i_reg_wr),
    .i_reg_sel(i_reg_sel), .i_reg_wdata(i_reg_wdata), .o_ctrl(o_ctrl), .o_data(o_data),
    .i_sda(sda_line), .o_sda(), .o_sda_oe(dut_sda_oe), .i_scl(scl_line), .o_scl(),
    .o_scl_oe(dut_scl_oe));
  smbus_target_model smbus_target_model_i (
    .i_scl(scl_line), .i_sda(sda_line), .i_rd_byte(RD), .o_sda_oe(mdl_sda_oe),
    .o_got(mdl_got));
  initial begin
    forever #10 i_clock = ~i_clock;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one write cycle on the cpu port
  task automatic wr(input logic sel, input logic [7:0] d);
    @(posedge i_clock);
    i_reg_wr <= 1'b1;
    i_reg_sel <= sel;
    i_reg_wdata <= d;
    @(posedge i_clock);
    i_reg_wr <= 1'b0;
  endtask
  // bounded wait for a control bit; looks only once outputs have settled
  task automatic wait_ctrl(input int b, input logic v);
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      #2;
      n++;
    end while (o_ctrl[b] !== v && n < 3000);
    chk({7'h00, o_ctrl[b]}, {7'h00, v});
  endtask
  // controller write: address with write bit, one data byte, stop
  task automatic write_xfer();
    wr(1'b0, 8'h20);
    wait_ctrl(0, 1'b1);
    chk(o_ctrl, 8'hE1);
    wr(1'b1, 8'hA4);
    wr(1'b0, 8'h00);
    wait_ctrl(0, 1'b1);
    chk(mdl_got, 8'hA4);
    chk(o_ctrl, 8'hC3);
    wr(1'b1, 8'h3C);
    wr(1'b0, 8'h00);
    wait_ctrl(0, 1'b1);
    chk(mdl_got, 8'h3C);
    chk(o_data, 8'h3C);
    wr(1'b0, 8'h10);
    wait_ctrl(7, 1'b0);
    // a stop leaves the direction flag as the last frame set it
    chk(o_ctrl, 8'h40);
  endtask
  // controller read of two bytes, then a late data write turns it round
  task automatic read_xfer();
    wr(1'b0, 8'h20);
    wait_ctrl(0, 1'b1);
    wr(1'b1, 8'hA5);
    wr(1'b0, 8'h00);
    wait_ctrl(0, 1'b1);
    chk(mdl_got, 8'hA5);
    wr(1'b0, 8'h00);
    wait_ctrl(0, 1'b1);
    chk(o_ctrl, 8'h89);
    chk(o_data, RD);
    wr(1'b0, 8'h02);
    wait_ctrl(0, 1'b1);
    chk(o_ctrl, 8'h8B);
    wr(1'b1, 8'h00);
    wr(1'b0, 8'h02);
    wait_ctrl(0, 1'b1);
    chk(o_ctrl, 8'hC1);
    chk(o_data, 8'h00);
    wr(1'b0, 8'h10);
    wait_ctrl(7, 1'b0);
    chk(o_ctrl, 8'h40);
  endtask
  // sda held low under our first '1' bit, then a foreign stop
  task automatic lose_xfer();
    wr(1'b0, 8'h20);
    wait_ctrl(0, 1'b1);
    wr(1'b1, 8'hFF);
    @(posedge i_clock);
    tb_sda_oe <= 1'b1;
    wr(1'b0, 8'h00);
    wait_ctrl(2, 1'b1);
    chk(o_ctrl, 8'h05);
    chk(o_data, 8'hFE);
    chk({6'h00, dut_sda_oe, dut_scl_oe}, 8'h00);
    @(posedge i_clock);
    tb_sda_oe <= 1'b0;
    wait_ctrl(4, 1'b1);
    chk(o_ctrl, 8'h15);
    wr(1'b0, 8'h00);
    @(posedge i_clock);
    #2;
    chk(o_ctrl, 8'h00);
  endtask
  // disable while idle: lines stay released, flags stay clear
  task automatic enable_off();
    @(posedge i_clock);
    i_enable <= 1'b0;
    repeat (4) @(posedge i_clock);
    i_enable <= 1'b1;
    repeat (2) @(posedge i_clock);
    #2;
    chk({6'h00, dut_sda_oe, dut_scl_oe}, 8'h00);
    chk(o_ctrl, 8'h00);
  endtask
  task automatic test_done();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // a hang costs far more than the thousand or fewer cycles expected
  initial begin
    #400000;
    miscompares++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge i_clock);
    i_rst_b <= 1'b1;
    @(posedge i_clock);
    #2;
    chk(o_ctrl, 8'h00);
    chk(o_data, 8'h00);
    write_xfer();
    read_xfer();
    lose_xfer();
    enable_off();
    test_done();
  end
endmodule

// >>> smbus_flags_cfg.svh
/*
  Constants for the serial flag and controller-mode block: register
  selects, control bit positions, reset values and bit timing.
  Assumes a 50 MHz system clock; included by bare name.
*/
`ifndef SMBUS_FLAGS_CFG_SVH
`define SMBUS_FLAGS_CFG_SVH

// register select on the cpu port
`define SB_CTRL_SEL 1'b0
`define SB_DATA_SEL 1'b1

// control register bit positions
`define SB_BIT_ROLE 7
`define SB_BIT_SENDING 6
`define SB_BIT_BEGIN 5
`define SB_BIT_END 4
`define SB_BIT_REPLY_NEEDED 3
`define SB_BIT_CONTENTION 2
`define SB_BIT_REPLY_POL 1
`define SB_BIT_BYTE_EVENT 0

// reset values
`define SB_CTRL_RST 8'h00
`define SB_DATA_RST 8'h00

// timing: half of one scl period, least time, rounded up to cycles
`define SB_CLK_NS 20
`define SB_HALF_NS 2500
`define SB_HALF_CYC ((`SB_HALF_NS + `SB_CLK_NS - 1) / `SB_CLK_NS)

`endif

// >>> smbus_flags_pkg.sv
/*
  Types for the serial flag and controller-mode block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package smbus_flags_pkg;

  // control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic role;          // controller role
    logic sending;       // sending direction
    logic begin_req;     // begin request
    logic end_req;       // end request
    logic reply_needed;  // reply needed
    logic contention;    // contention lost
    logic reply_pol;     // reply polarity
    logic byte_event;    // byte event, stalls the bus
  } ctrl_t;

  // gray along idle -> cond -> hold -> bits
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_COND = 3'h1,
    ST_HOLD = 3'h3,
    ST_BITS = 3'h2
  } state_t;

endpackage

// >>> smbus_flags_sva.sv
/*
  Port checks for the serial flag and controller-mode block.
  Assumes it is bound to the design top; one clock domain.
*/
module smbus_flags_sva #(
  parameter int HALF_CYC = 4
) (
  input logic i_clock,
  input logic i_rst_b,
  input logic i_enable,
  input logic i_reg_wr,
  input logic i_reg_sel,
  input logic [7:0] i_reg_wdata,
  input smbus_flags_pkg::ctrl_t o_ctrl,
  input logic [7:0] o_data,
  input logic i_sda,
  input logic o_sda,
  input logic o_sda_oe,
  input logic i_scl,
  input logic o_scl,
  input logic o_scl_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // software clear of the byte event
  logic ev_clr;
  assign ev_clr = i_reg_wr && (i_reg_sel == 1'b0) && !i_reg_wdata[0];
  // ack slot of a received byte: event cleared, scl let go
  sequence ack_slot_s;
    o_ctrl.reply_needed && !o_ctrl.byte_event && !o_scl_oe;
  endsequence
  stall_hold_a: assert property (
    ($past(o_ctrl.byte_event) && o_ctrl.byte_event && o_ctrl.role) |-> o_scl_oe)
    else $error("scl released while stalled");
  event_keep_a: assert property (
    (o_ctrl.byte_event && i_enable && !ev_clr) |=> o_ctrl.byte_event)
    else $error("byte event dropped without software");
  contention_clear_a: assert property (
    $fell(o_ctrl.byte_event) |-> !o_ctrl.contention)
    else $error("contention kept after event clear");
  role_start_a: assert property (
    $rose(o_ctrl.role) |-> (o_ctrl.byte_event && o_ctrl.sending))
    else $error("start without event or sending");
  role_drop_a: assert property (
    ($fell(o_ctrl.role) && $past(i_enable))
    |-> (o_ctrl.contention || ($past(o_ctrl.end_req) && !o_ctrl.end_req)))
    else $error("role dropped without stop or loss");
  reply_drive_a: assert property (
    ack_slot_s |-> (o_sda_oe == o_ctrl.reply_pol))
    else $error("ack bit differs from reply polarity");
  reply_set_a: assert property (
    $rose(o_ctrl.reply_needed) |-> ($rose(o_ctrl.byte_event) && !o_ctrl.sending))
    else $error("reply needed without receive event");
  idle_release_a: assert property (
    !i_enable |-> ##[1:2] (!o_sda_oe && !o_scl_oe))
    else $error("lines held while disabled");
  open_drain_a: assert property (
    (o_sda == 1'b0) && (o_scl == 1'b0))
    else $error("open drain output driven high");
endmodule

bind smbus_flags_and_controller_modes smbus_flags_sva #(.HALF_CYC(HALF_CYC)) smbus_flags_sva_i (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_enable(i_enable), .i_reg_wr(i_reg_wr),
  .i_reg_sel(i_reg_sel), .i_reg_wdata(i_reg_wdata), .o_ctrl(o_ctrl), .o_data(o_data),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_scl(i_scl), .o_scl(o_scl),
  .o_scl_oe(o_scl_oe));

// >>> smbus_target_model.sv
/*
  Behavioural bus target: takes any address, acks written bytes,
  returns a fixed byte on reads until the controller nacks.
  Assumes resolved, pulled-up sda and scl lines.
*/
module smbus_target_model (
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [7:0] i_rd_byte,
  output logic o_sda_oe,
  output logic [7:0] o_got
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  logic rd = 1'b0;
  logic addr = 1'b0;
  logic act = 1'b0;
  logic [7:0] sh = 8'h00;
  initial o_sda_oe = 1'b0;
  initial o_got = 8'h00;
  // start opens a frame with the address, stop closes it
  always @(negedge i_sda) if (i_scl === 1'b1) begin
    cnt = 0;
    addr = 1'b1;
    act = 1'b1;
  end
  always @(posedge i_sda) if (i_scl === 1'b1) act = 1'b0;
  // sample on the rise; a nack on a read ends our drive
  always @(posedge i_scl) if (act) begin
    if (cnt < 8) sh = {sh[6:0], i_sda};
    if (cnt == 7) o_got = sh;
    if (cnt == 7 && addr) rd = i_sda;
    if (cnt == 8 && rd && !addr && i_sda) act = 1'b0;
    cnt++;
  end
  // change sda only after scl falls, never while it is high
  always @(negedge i_scl) begin
    o_sda_oe = 1'b0;
    if (act) begin
      if (cnt == 9) begin
        cnt = 0;
        addr = 1'b0;
      end
      if (cnt == 8) o_sda_oe = !rd || addr;
      else o_sda_oe = rd && !addr && !i_rd_byte[7-cnt];
    end
  end
endmodule
